// ### dv/tb_top.sv
// Self-checking bench for the exchange core.
// Assumes the host model drives APB; switches held static except sw_bin, raised for the binary test.
`timescale 1ns/10ps
module tb_top;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, at_done, e, sw_bin;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, q, lfsr;
  logic [111:0] core_in;
  logic [47:0]  core_out, at_pid;
  logic [6:0]   unit;
  logic [15:0]  v;
  int           n_mismatch, checks_done;
  tcx_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  tcx_exchange DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sw_binary_pin(sw_bin), .sw_nvload_pin(1'b0), .unit_no_pin(unit),
    .core_in(core_in), .autotune_done(at_done), .autotune_pid(at_pid),
    .core_out(core_out), .irq(irq));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // Values above 9999 overflow the thousands digit, so callers stay below
  function automatic logic [31:0] bcd(input logic [15:0] b);
    return {16'h0, 4'(b / 1000), 4'(b / 100 % 10), 4'(b / 10 % 10), 4'(b % 10)};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Clock, 8 ns period
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Watchdog, far beyond the 45 transfers expected
  initial
  begin
    #400000;
    n_mismatch++;
    give_verdict();
  end
  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    lfsr = 32'h6485d3c2;
    n_mismatch = 0;
    checks_done = 0;
    presetn = 1'b0;
    core_in = '0;
    at_done = 1'b0;
    sw_bin = 1'b0;
    at_pid = '0;
    unit = 7'(rnd() % 95);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(tcx_pkg::A_BASES);
    chk("bases", q, {16'(20000 + 100 * unit), 16'(2000 + 10 * unit)});
    $display("test bases done");
    // Refresh both ways, 9999 edge first, then random words
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 16'h270f : 16'(rnd() % 10000);
      core_in <= {96'h0, v};
      wr(tcx_pkg::A_CTRL, 32'h1);
      rd(tcx_pkg::A_CIO + 12'h00c);
      chk("cio_in", q, bcd(v));
      wr(tcx_pkg::A_CIO, bcd(v));
      wr(tcx_pkg::A_DM + 12'h0a0, bcd(v));
      wr(tcx_pkg::A_CTRL, 32'h1);
      // Output register updates on the completing edge; look one edge later
      @(posedge pclk);
      chk("core_out", {16'h0, core_out[15:0]}, {16'h0, v});
      rd(tcx_pkg::A_RAM + 12'h0a0);
      chk("ram_param", q, {16'h0, v});
    end
    $display("test refresh done");
    // PID words follow the flag before the write, autotune overrides
    wr(tcx_pkg::A_DM + 12'h078, bcd(16'd111));
    wr(tcx_pkg::A_CTRL, 32'h9);
    wr(tcx_pkg::A_DM + 12'h078, bcd(16'd222));
    wr(tcx_pkg::A_CTRL, 32'h9);
    rd(tcx_pkg::A_RAM + 12'h078);
    chk("pid_kept", q, 32'd111);
    at_pid <= {32'h0, 16'd555};
    at_done <= 1'b1;
    @(posedge pclk);
    at_done <= 1'b0;
    rd(tcx_pkg::A_RAM + 12'h078);
    chk("pid_tuned", q, 32'd555);
    wr(tcx_pkg::A_CTRL, 32'h0);
    $display("test pid done");
    // Init word only taken on falling restart bit
    wr(tcx_pkg::A_DM + 12'h014, bcd(16'd77));
    wr(tcx_pkg::A_CTRL, 32'h1);
    wr(tcx_pkg::A_CTRL, 32'h2);
    repeat (3) @(posedge pclk);
    rd(tcx_pkg::A_RAM + 12'h014);
    chk("init_held", q, 32'h0);
    wr(tcx_pkg::A_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    rd(tcx_pkg::A_RAM + 12'h014);
    chk("init_taken", q, 32'd77);
    $display("test restart done");
    // Save raises masked interrupt; status read clears it
    wr(tcx_pkg::A_IMASK, 32'h4);
    rd(tcx_pkg::A_ISTAT);
    wr(tcx_pkg::A_CTRL, 32'h4);
    repeat (4) @(posedge pclk);
    chk("irq_set", {31'h0, irq}, 32'h1);
    rd(tcx_pkg::A_ISTAT);
    chk("save_done", q & 32'h4, 32'h4);
    @(posedge pclk);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    rd(12'h080);
    chk("unmapped", {q[30:0], e}, 32'h1);
    $display("test save done");
    // Binary format: input words pass through unconverted
    sw_bin <= 1'b1;
    repeat (4) @(posedge pclk);
    v = 16'(rnd());
    core_in <= {96'h0, v};
    wr(tcx_pkg::A_CTRL, 32'h1);
    rd(tcx_pkg::A_CIO + 12'h00c);
    chk("cio_bin", q, {16'h0, v});
    $display("test binary done");
    give_verdict();
  end
endmodule

// ### dv/tcx_host_model.sv
// Host controller model: APB master reaching the exchange words.
// Assumes the bench calls xfer from one process, pready answers.
`timescale 1ns/10ps
module tcx_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus; one module on two reserved unit numbers
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Restart bit mapped into CTRL b1 saves kept rare
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### hdl/tcx_exchange.sv
// Data exchange core of a plug-in control module: APB slave holding the
// host word areas, refresh, restart, parameter RAM and save logic.
// Assumes an APB master on pclk; switch pins are asynchronous.
//
// Overview of operation
// - Words are 16-bit binary with format switch on, four-digit BCD otherwise.
// - One format applies to every word in both host areas.
// - Operation words of unit n start at 2000+10n and span 20 words.
// - Parameter words of unit n start at 20000+100n and span 100 words.
// - Restart happens only when the restart bit goes on and then off.
// - Operation data lives in control-io words, init and parameters in data memory.
// - Operation data is exchanged once per refresh.
// - Init data is taken only at power-on or restart.
// - Operating parameters are copied into RAM every refresh.
// - PID words are copied only while the PID-changed flag is off.
// - Autotune completion writes computed PID constants into RAM.
// - Save bit writes parameters to nonvolatile memory; nothing else stored.
// - With load switch on, stored parameters go to host words at init.
// - Each refresh sends input words to host and takes output words.
`timescale 1ns/10ps
module tcx_exchange (
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [11:0]                            paddr,
  input  wire logic [31:0]                            pwdata,
  output logic      [31:0]                            prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  input  wire logic                                   sw_binary_pin,
  input  wire logic                                   sw_nvload_pin,
  input  wire logic [6:0]                             unit_no_pin,
  input  wire logic [tcx_pkg::IN_WORDS*16-1:0]        core_in,
  input  wire logic                                   autotune_done,
  input  wire logic [tcx_pkg::PID_WORDS*16-1:0]       autotune_pid,
  output logic      [tcx_pkg::OUT_WORDS*16-1:0]       core_out,
  output logic                                        irq
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic                                       bin_s1;
    logic                                       bin_s2;
    logic                                       nvl_s1;
    logic                                       nvl_s2;
    logic [6:0]                                 unit_s1;
    logic [6:0]                                 unit_s2;
    logic [tcx_pkg::CIO_WORDS-1:0][15:0]        control_io_area;
    tcx_pkg::tcx_dm_t                           dm;
    tcx_pkg::tcx_dm_t                           ram;
    logic [tcx_pkg::OUT_WORDS-1:0][15:0]        core_out;
    logic                                       restart_bit;
    logic                                       pid_chg;
    logic [1:0]                                 init_wait;
    logic                                       save;
    logic [15:0]                                refreshes;
    logic [tcx_pkg::EV_W-1:0]                   irq_stat;
    logic [tcx_pkg::EV_W-1:0]                   irq_mask;
    logic                                       irq;
    logic [31:0]                                prdata;
    logic                                       pready;
    logic                                       pslverr;
  } tcx_st_t;

  tcx_st_t                              st_q;
  tcx_st_t                              st_d;
  tcx_pkg::tcx_hit_t                    hit;
  logic [6:0]                           idx;
  logic                                 acc;
  logic                                 wr_ctrl;
  logic                                 refresh_go;
  logic                                 save_go;
  logic                                 init_go;
  logic [15:0]                          cio_base;
  logic [15:0]                          dm_base;
  tcx_pkg::tcx_dm_t                     dm_bin;
  tcx_pkg::tcx_dm_t                     nv_fmt;
  logic [tcx_pkg::CIO_WORDS-1:0][15:0]  cio_bin;
  logic [tcx_pkg::CIO_WORDS-1:0][15:0]  in_bin;
  logic [tcx_pkg::CIO_WORDS-1:0][15:0]  in_fmt;

  tcx_nv_if nv ();

  // ***************************************************************
  // Converters and nonvolatile store
  // ***************************************************************
  // Data-memory words to binary, stored parameters back to host format
  tcx_fmt_conv #(.N(tcx_pkg::DM_WORDS)) u_dm_conv (
    .sel_binary (st_q.bin_s2),
    .fmt_in     (st_q.dm),
    .bin_out    (dm_bin),
    .bin_in     (nv.rdata),
    .fmt_out    (nv_fmt)
  );

  // Operation words: outputs to binary, core inputs to host format
  tcx_fmt_conv #(.N(tcx_pkg::CIO_WORDS)) u_cio_conv (
    .sel_binary (st_q.bin_s2),
    .fmt_in     (st_q.control_io_area),
    .bin_out    (cio_bin),
    .bin_in     (in_bin),
    .fmt_out    (in_fmt)
  );

  tcx_nv_store u_nv (
    .pclk    (pclk),
    .presetn (presetn),
    .nv      (nv)
  );

  assign nv.save  = st_q.save;
  assign nv.wdata = st_q.ram;

  // Core input words placed at their operation-word slots
  always_comb
  begin
    in_bin = '0;
    for (int i = 0; i < tcx_pkg::IN_WORDS; i++)
      in_bin[tcx_pkg::IN_FIRST+i] = core_in[i*16 +: 16];
  end

  // ***************************************************************
  // Address decode and strobes
  // ***************************************************************
  // Unit bases, readable so software can check its allocation
  assign cio_base = tcx_pkg::CIO_BASE0 + 16'(st_q.unit_s2) * tcx_pkg::CIO_STEP;
  assign dm_base  = tcx_pkg::DM_BASE0 + 16'(st_q.unit_s2) * tcx_pkg::DM_STEP;

  always_comb
  begin
    idx = '0;
    hit = tcx_pkg::H_NONE;
    if (paddr == tcx_pkg::A_CTRL)
      hit = tcx_pkg::H_CTRL;
    else if (paddr == tcx_pkg::A_STATUS)
      hit = tcx_pkg::H_STAT;
    else if (paddr == tcx_pkg::A_BASES)
      hit = tcx_pkg::H_BASE;
    else if (paddr == tcx_pkg::A_ISTAT)
      hit = tcx_pkg::H_ISTAT;
    else if (paddr == tcx_pkg::A_IMASK)
      hit = tcx_pkg::H_IMASK;
    else if (paddr[1:0] == 2'h0 && paddr >= tcx_pkg::A_CIO
             && paddr < tcx_pkg::A_CIO + 12'(4 * tcx_pkg::CIO_WORDS))
    begin
      hit = tcx_pkg::H_CIO;
      idx = 7'((paddr - tcx_pkg::A_CIO) >> 2);
    end
    else if (paddr[1:0] == 2'h0 && paddr >= tcx_pkg::A_DM
             && paddr < tcx_pkg::A_DM + 12'(4 * tcx_pkg::DM_WORDS))
    begin
      hit = tcx_pkg::H_DM;
      idx = 7'((paddr - tcx_pkg::A_DM) >> 2);
    end
    else if (paddr[1:0] == 2'h0 && paddr >= tcx_pkg::A_RAM
             && paddr < tcx_pkg::A_RAM + 12'(4 * tcx_pkg::DM_WORDS))
    begin
      hit = tcx_pkg::H_RAM;
      idx = 7'((paddr - tcx_pkg::A_RAM) >> 2);
    end
  end

  // Transfer completes on the edge that sees pready high
  assign acc        = psel && penable && st_q.pready;
  assign wr_ctrl    = acc && pwrite && hit == tcx_pkg::H_CTRL;
  assign refresh_go = wr_ctrl && pwdata[tcx_pkg::C_REFRESH];
  assign save_go    = wr_ctrl && pwdata[tcx_pkg::C_SAVE];
  assign init_go    = st_q.init_wait == 2'h1;

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    st_d          = st_q;
    st_d.bin_s1   = sw_binary_pin;
    st_d.bin_s2   = st_q.bin_s1;
    st_d.nvl_s1   = sw_nvload_pin;
    st_d.nvl_s2   = st_q.nvl_s1;
    st_d.unit_s1  = unit_no_pin;
    st_d.unit_s2  = st_q.unit_s1;
    st_d.pready   = 1'b0;
    st_d.pslverr  = 1'b0;
    st_d.save     = save_go;
    if (st_q.init_wait != 2'h0)
      st_d.init_wait = st_q.init_wait - 2'h1;

    // Access phase: answer one cycle after penable rises
    if (psel && penable && !st_q.pready)
    begin
      st_d.pready = 1'b1;
      st_d.prdata = '0;
      case (hit)
        tcx_pkg::H_CTRL:  st_d.prdata = 32'({st_q.pid_chg, 1'b0, st_q.restart_bit, 1'b0});
        tcx_pkg::H_STAT:  st_d.prdata = {st_q.refreshes, 6'h00, st_q.unit_s2,
                                         st_q.init_wait != 2'h0, st_q.nvl_s2, st_q.bin_s2};
        tcx_pkg::H_BASE:  st_d.prdata = {dm_base, cio_base};
        tcx_pkg::H_ISTAT: st_d.prdata = 32'(st_q.irq_stat);
        tcx_pkg::H_IMASK: st_d.prdata = 32'(st_q.irq_mask);
        tcx_pkg::H_CIO:   st_d.prdata = 32'(st_q.control_io_area[idx]);
        tcx_pkg::H_DM:    st_d.prdata = 32'(st_q.dm[idx]);
        tcx_pkg::H_RAM:   st_d.prdata = 32'(st_q.ram[idx]);
        default:          st_d.pslverr = 1'b1; // Unmapped address
      endcase
    end

    // Writes take effect on the completing edge only
    if (acc && pwrite)
    begin
      case (hit)
        tcx_pkg::H_CTRL:
        begin
          st_d.restart_bit = pwdata[tcx_pkg::C_RESTART];
          st_d.pid_chg     = pwdata[tcx_pkg::C_PIDCHG];
        end
        tcx_pkg::H_IMASK: st_d.irq_mask = pwdata[tcx_pkg::EV_W-1:0];
        // Device-driven input words are not host-writable
        tcx_pkg::H_CIO:
          if (idx < 7'(tcx_pkg::IN_FIRST) || idx >= 7'(tcx_pkg::IN_FIRST + tcx_pkg::IN_WORDS))
            st_d.control_io_area[idx] = pwdata[15:0];
        tcx_pkg::H_DM:    st_d.dm[idx] = pwdata[15:0];
        default:          st_d.irq_stat = st_q.irq_stat;
      endcase
    end

    // Reading the status clears it; events below still win
    if (acc && !pwrite && hit == tcx_pkg::H_ISTAT)
      st_d.irq_stat = '0;

    // Only the on-to-off transition restarts, a held level does nothing
    if (st_q.restart_bit && wr_ctrl && !pwdata[tcx_pkg::C_RESTART])
      st_d.init_wait = 2'h1;

    // Refresh: operation exchange and parameter copy
    if (refresh_go)
    begin
      for (int i = 0; i < tcx_pkg::IN_WORDS; i++)
        st_d.control_io_area[tcx_pkg::IN_FIRST+i] = in_fmt[tcx_pkg::IN_FIRST+i];
      for (int i = 0; i < tcx_pkg::OUT_WORDS; i++)
        st_d.core_out[i] = cio_bin[tcx_pkg::OUT_FIRST+i];
      for (int i = tcx_pkg::INIT_WORDS; i < tcx_pkg::DM_WORDS; i++)
        // PID words stay put while the host says they were changed locally
        if (!(st_q.pid_chg && i >= tcx_pkg::PID_FIRST
              && i < tcx_pkg::PID_FIRST + tcx_pkg::PID_WORDS))
          st_d.ram[i] = dm_bin[i];
      st_d.refreshes = st_q.refreshes + 16'h0001;
      st_d.irq_stat[tcx_pkg::EV_REFRESH] = 1'b1;
    end

    // Autotune result overrides a same-cycle refresh copy
    if (autotune_done)
    begin
      for (int i = 0; i < tcx_pkg::PID_WORDS; i++)
        st_d.ram[tcx_pkg::PID_FIRST+i] = autotune_pid[i*16 +: 16];
      st_d.irq_stat[tcx_pkg::EV_TUNE] = 1'b1;
    end

    // Power-on or restart: init words, optional reload of stored parameters
    if (init_go)
    begin
      for (int i = 0; i < tcx_pkg::INIT_WORDS; i++)
        st_d.ram[i] = dm_bin[i];
      for (int i = tcx_pkg::INIT_WORDS; i < tcx_pkg::DM_WORDS; i++)
        if (st_q.nvl_s2)
        begin
          st_d.dm[i]  = nv_fmt[i];
          st_d.ram[i] = nv.rdata[i];
        end
        else
          st_d.ram[i] = dm_bin[i];
      st_d.irq_stat[tcx_pkg::EV_INIT] = 1'b1;
    end

    if (st_q.save)
      st_d.irq_stat[tcx_pkg::EV_SAVE] = 1'b1;
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q           <= '0;
      st_q.init_wait <= tcx_pkg::INIT_WAIT;
    end
    else
      st_q <= st_d;
  end

  assign prdata   = st_q.prdata;
  assign pready   = st_q.pready;
  assign pslverr  = st_q.pslverr;
  assign core_out = st_q.core_out;
  assign irq      = st_q.irq;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_fmt_binary;
    refresh_go && st_q.bin_s2 |=> core_out[15:0] == $past(st_q.control_io_area[0]);
  endproperty
  a_fmt_binary: assert property (p_fmt_binary)
    else $error("binary word not passed through");

  property p_fmt_bcd;
    refresh_go && !st_q.bin_s2 && st_q.control_io_area[0] == 16'h1234 |=> core_out[15:0] == 16'h04d2;
  endproperty
  a_fmt_bcd: assert property (p_fmt_bcd)
    else $error("bcd word not converted");

  property p_restart_edge;
    st_q.restart_bit && wr_ctrl && !pwdata[tcx_pkg::C_RESTART] |=> init_go ##1 !init_go;
  endproperty
  a_restart_edge: assert property (p_restart_edge)
    else $error("restart not taken on falling bit");

  property p_no_spurious_init;
    !init_go && st_q.init_wait == 2'h0 && !(st_q.restart_bit && wr_ctrl) |=> !init_go;
  endproperty
  a_no_spurious_init: assert property (p_no_spurious_init)
    else $error("restart without on-off sequence");

  property p_refresh_count;
    refresh_go |=> st_q.refreshes == $past(st_q.refreshes) + 16'h0001;
  endproperty
  a_refresh_count: assert property (p_refresh_count)
    else $error("refresh not counted");

  property p_init_hold;
    !init_go |=> st_q.ram[0] == $past(st_q.ram[0]);
  endproperty
  a_init_hold: assert property (p_init_hold)
    else $error("init word changed outside init");

  property p_param_copy;
    refresh_go && !init_go |=> st_q.ram[tcx_pkg::INIT_WORDS] == $past(dm_bin[tcx_pkg::INIT_WORDS]);
  endproperty
  a_param_copy: assert property (p_param_copy)
    else $error("parameter not copied on refresh");

  property p_pid_hold;
    refresh_go && st_q.pid_chg && !autotune_done && !init_go
      |=> $stable(st_q.ram[tcx_pkg::PID_FIRST]);
  endproperty
  a_pid_hold: assert property (p_pid_hold)
    else $error("pid word overwritten while flag set");

  property p_tune_store;
    autotune_done && !init_go |=> st_q.ram[tcx_pkg::PID_FIRST] == $past(autotune_pid[15:0]);
  endproperty
  a_tune_store: assert property (p_tune_store)
    else $error("autotune result not stored");

  property p_save_pulse;
    save_go |=> nv.save ##1 nv.writes == $past(nv.writes) + 32'h0000_0001;
  endproperty
  a_save_pulse: assert property (p_save_pulse)
    else $error("save did not reach the store");

  property p_nv_load;
    init_go && st_q.nvl_s2 |=> st_q.dm[tcx_pkg::INIT_WORDS] == $past(nv_fmt[tcx_pkg::INIT_WORDS]);
  endproperty
  a_nv_load: assert property (p_nv_load)
    else $error("stored parameter not reloaded");

  property p_in_word;
    refresh_go |=> st_q.control_io_area[tcx_pkg::IN_FIRST] == $past(in_fmt[tcx_pkg::IN_FIRST]);
  endproperty
  a_in_word: assert property (p_in_word)
    else $error("input word not sent");

  c_refresh: cover property (refresh_go ##[1:20] refresh_go);
  c_restart: cover property (st_q.restart_bit ##[1:20] init_go);
  c_save:    cover property (save_go ##1 nv.save);
  c_tune:    cover property (autotune_done && st_q.pid_chg);
endmodule

// ### hdl/tcx_fmt_conv.sv
// Word format converter between host format and internal binary.
// Assumes sel_binary is a settled level; purely combinational.
`timescale 1ns/10ps
module tcx_fmt_conv #(
  parameter int N = 1
) (
  input  wire logic                  sel_binary,
  input  wire logic [N-1:0][15:0]    fmt_in,
  output logic      [N-1:0][15:0]    bin_out,
  input  wire logic [N-1:0][15:0]    bin_in,
  output logic      [N-1:0][15:0]    fmt_out
);

  // ***************************************************************
  // One converter pair per word
  // ***************************************************************
  for (genvar i = 0; i < N; i++) begin : g_word
    logic [15:0] clip;
    logic [15:0] dec;
    // Out-of-range binary saturates at 9999 rather than wrapping
    assign clip = (bin_in[i] > tcx_pkg::BCD_MAX) ? tcx_pkg::BCD_MAX : bin_in[i];
    assign dec  = 16'(fmt_in[i][15:12]) * tcx_pkg::DEC3
                + 16'(fmt_in[i][11:8]) * tcx_pkg::DEC2
                + 16'(fmt_in[i][7:4]) * tcx_pkg::DEC1
                + 16'(fmt_in[i][3:0]);
    assign bin_out[i] = sel_binary ? fmt_in[i] : dec;
    assign fmt_out[i] = sel_binary ? bin_in[i] :
                        {4'(clip / tcx_pkg::DEC3),
                         4'((clip / tcx_pkg::DEC2) % tcx_pkg::DEC1),
                         4'((clip / tcx_pkg::DEC1) % tcx_pkg::DEC1),
                         4'(clip % tcx_pkg::DEC1)};
  end
endmodule

// ### hdl/tcx_nv_if.sv
// Link between the exchange core and its nonvolatile parameter store.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface tcx_nv_if;
  logic             save;
  tcx_pkg::tcx_dm_t wdata;
  tcx_pkg::tcx_dm_t rdata;
  logic [31:0]      writes;
  modport ctl (output save, output wdata, input rdata, input writes);
  modport mem (input save, input wdata, output rdata, output writes);
endinterface

// ### hdl/tcx_nv_store.sv
// Nonvolatile store for the operating parameter words.
// Assumes presetn models loss of power; only parameter words are kept.
`timescale 1ns/10ps
module tcx_nv_store (
  input  wire logic pclk,
  input  wire logic presetn,
  tcx_nv_if.mem     nv
);

  typedef struct packed {
    tcx_pkg::tcx_dm_t words;
    logic [31:0]      writes;
  } tcx_nv_st_t;

  tcx_nv_st_t st_q;
  tcx_nv_st_t st_d;

  // ***************************************************************
  // Save: parameter words only, init words never stored
  // ***************************************************************
  always_comb
  begin
    st_d = st_q;
    if (nv.save)
    begin
      for (int i = tcx_pkg::INIT_WORDS; i < tcx_pkg::DM_WORDS; i++)
        st_d.words[i] = nv.wdata[i];
      st_d.writes = st_q.writes + 32'h0000_0001; // Wear counter, endurance is limited
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign nv.rdata  = st_q.words;
  assign nv.writes = st_q.writes;
endmodule

// ### hdl/tcx_pkg.sv
// Constants and types shared by the module data exchange block.
// Assumes one 125 MHz APB clock domain and 16-bit host words.
package tcx_pkg;

  // ***************************************************************
  // Word areas
  // ***************************************************************
  localparam int WORD_W     = 16;
  localparam int CIO_WORDS  = 20;  // Operation words per unit
  localparam int DM_WORDS   = 100; // Initialization and parameter words
  localparam int INIT_WORDS = 20;  // Leading data-memory words that are init data
  localparam int OUT_FIRST  = 0;   // Host-to-device operation words
  localparam int OUT_WORDS  = 3;
  localparam int IN_FIRST   = 3;   // Device-to-host operation words
  localparam int IN_WORDS   = 7;
  localparam int PID_FIRST  = 30;  // Proportional band, integral, derivative
  localparam int PID_WORDS  = 3;

  localparam logic [15:0] CIO_BASE0 = 16'h07d0; // Word 2000
  localparam logic [15:0] CIO_STEP  = 16'h000a; // Ten words per unit number
  localparam logic [15:0] DM_BASE0  = 16'h4e20; // Word 20000
  localparam logic [15:0] DM_STEP   = 16'h0064; // Hundred words per unit number

  // Decimal weights for four-digit BCD
  localparam logic [15:0] DEC1    = 16'h000a;
  localparam logic [15:0] DEC2    = 16'h0064;
  localparam logic [15:0] DEC3    = 16'h03e8;
  localparam logic [15:0] BCD_MAX = 16'h270f;

  // ***************************************************************
  // Register map (byte addresses)
  // ***************************************************************
  localparam logic [11:0] A_CTRL   = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_BASES  = 12'h008;
  localparam logic [11:0] A_ISTAT  = 12'h00c;
  localparam logic [11:0] A_IMASK  = 12'h010;
  localparam logic [11:0] A_CIO    = 12'h100;
  localparam logic [11:0] A_DM     = 12'h200;
  localparam logic [11:0] A_RAM    = 12'h400;

  localparam int C_REFRESH = 0;
  localparam int C_RESTART = 1;
  localparam int C_SAVE    = 2;
  localparam int C_PIDCHG  = 3;

  localparam int EV_W       = 4;
  localparam int EV_REFRESH = 0;
  localparam int EV_INIT    = 1;
  localparam int EV_SAVE    = 2;
  localparam int EV_TUNE    = 3;

  localparam logic [1:0] INIT_WAIT = 2'h3; // Lets the switch synchronisers settle

  typedef logic [WORD_W-1:0]               tcx_word_t;
  typedef logic [DM_WORDS-1:0][WORD_W-1:0] tcx_dm_t;
  typedef enum logic [3:0] {H_CTRL, H_STAT, H_BASE, H_ISTAT, H_IMASK,
                            H_CIO, H_DM, H_RAM, H_NONE} tcx_hit_t;
endpackage
